// *** design/ssa_regs.svh ***
/*
 * Constants of the simultaneous-sampling converter sequencer and its host.
 * Assumes a 250 MHz system clock shared by both ends.
 */
`ifndef SSA_REGS_SVH
`define SSA_REGS_SVH

`define SSA_CLK_MHZ      250
`define SSA_DATA_W       12
`define SSA_CHANNELS     4
`define SSA_MASK_LSB     0
`define SSA_MASK_W       4
`define SSA_CNT_W        9
`define SSA_CONV_TIME_NS 1650
`define SSA_ACQ_TIME_NS  350
`define SSA_GAP_TIME_NS  100
`define SSA_CONV_CYC     ((`SSA_CONV_TIME_NS * `SSA_CLK_MHZ + 999) / 1000)
`define SSA_ACQ_CYC      ((`SSA_ACQ_TIME_NS * `SSA_CLK_MHZ + 999) / 1000)
`define SSA_GAP_CYC      ((`SSA_GAP_TIME_NS * `SSA_CLK_MHZ + 999) / 1000)
`define SSA_EXT_CLKS     14
`define SSA_EOC_CYC      4
`define SSA_START_CYC    4
`define SSA_STB_CYC      3
`define SSA_MASK_RST     4'hf

`endif

// *** design/ssa_pkg.sv ***
/*
 * Types shared by the converter sequencer, its host and the link interface.
 * Assumes ssa_regs.svh on the include path.
 */
`include "ssa_regs.svh"
`default_nettype none

package ssa_pkg;

   typedef logic [`SSA_DATA_W-1:0] ssa_word_t;
   typedef logic [`SSA_MASK_W-1:0] ssa_mask_t;
   typedef logic [`SSA_CNT_W-1:0]  ssa_cnt_t;

   typedef enum logic [1:0] {
      DEV_IDLE = 2'b00,
      DEV_CONV = 2'b01,
      DEV_EOC  = 2'b10,
      DEV_FIN  = 2'b11
   } ssa_dev_st_t;

   typedef enum logic [2:0] {
      HST_IDLE  = 3'b000,
      HST_WRITE = 3'b001,
      HST_START = 3'b010,
      HST_WAIT  = 3'b011,
      HST_READ  = 3'b100
   } ssa_hst_st_t;

   typedef struct packed {
      logic     active;
      logic     extPrev;
      ssa_cnt_t cnt;
      logic     done;
   } ssa_core_st_t;

   typedef struct packed {
      ssa_dev_st_t                     st;
      logic                            startPrev;
      ssa_mask_t                       chanSel;
      ssa_mask_t                       seqMask;
      logic [1:0]                      chan;
      logic [`SSA_CHANNELS-1:0][`SSA_DATA_W-1:0] held;
      logic [`SSA_CHANNELS-1:0][`SSA_DATA_W-1:0] res;
      logic [2:0]                      wrPos;
      logic [2:0]                      rdPos;
      logic                            rdPrev;
      logic [2:0]                      eocCnt;
      logic                            busy;
      logic                            eoc_n;
      logic                            hold;
      ssa_word_t                       dout;
      logic                            doutOe_n;
      logic                            coreStart;
   } ssa_dev_state_t;

   typedef struct packed {
      ssa_hst_st_t st;
      ssa_cnt_t    cnt;
      ssa_cnt_t    quiet;
      logic        busyPrev;
      logic        eocPrev;
      logic        seqEnd;
      logic [2:0]  nEoc;
      logic [2:0]  rdCnt;
      logic        start_n;
      logic        chipSel_n;
      logic        readStb_n;
      logic        writeStb_n;
      ssa_mask_t   hData;
      logic        hOe_n;
      logic        resValid;
      ssa_word_t   resData;
      logic [2:0]  resIdx;
      logic        ready;
   } ssa_hst_state_t;

endpackage : ssa_pkg

`default_nettype wire

// *** design/ssa_if.sv ***
/*
 * Parallel link between the host and the converter sequencer.
 * Assumes each end drives only its own signals; the shared data lines are resolved here.
 */
`include "ssa_regs.svh"
`default_nettype none

interface ssa_if;
   import ssa_pkg::*;

   logic      sampleStart_n;
   logic      chipSel_n;
   logic      readStb_n;
   logic      writeStb_n;
   ssa_word_t devData;
   logic      devOe_n;
   ssa_mask_t hostData;
   logic      hostOe_n;
   ssa_word_t dataBus;
   logic      busy;
   logic      eoc_n;

   // ---------------------------------------------------------------
   // Data line level
   // ---------------------------------------------------------------
   // The host drives only the four mask lines.
   assign dataBus = !devOe_n ? devData :
                    (!hostOe_n ? {{(`SSA_DATA_W-`SSA_MASK_W){1'b0}}, hostData} : '0);

   modport dev (input sampleStart_n, chipSel_n, readStb_n, writeStb_n, dataBus,
                output devData, devOe_n, busy, eoc_n);
   modport host (output sampleStart_n, chipSel_n, readStb_n, writeStb_n, hostData, hostOe_n,
                 input dataBus, busy, eoc_n);
endinterface : ssa_if

`default_nettype wire

// *** design/ssa_conv_core.sv ***
/*
 * Timer for one channel conversion, clocked internally or by the external clock.
 * Assumes the external conversion clock is synchronous to clk_sys and slower than half its rate.
 */
`include "ssa_regs.svh"
`default_nettype none

module ssa_conv_core
   import ssa_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic arst_n,
   input  wire logic ce,
   input  wire logic start,
   input  wire logic extSel,
   input  wire logic extClk,
   output logic      done
);

   ssa_core_st_t s_q;
   ssa_core_st_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.extPrev = extClk;
      if (start) begin
         s_d.active = 1'b1;
         s_d.cnt = '0;
      end else if (s_q.active) begin
         // Internal clock counts system cycles, external counts rising edges.
         if (extSel) begin
            if (extClk && !s_q.extPrev) begin
               s_d.cnt = s_q.cnt + 1'b1;
            end
            if (s_q.cnt == ssa_cnt_t'(`SSA_EXT_CLKS)) begin
               s_d.active = 1'b0;
               s_d.done = 1'b1;
            end
         end else begin
            s_d.cnt = s_q.cnt + 1'b1;
            if (s_q.cnt == ssa_cnt_t'(`SSA_CONV_CYC - 1)) begin
               s_d.active = 1'b0;
               s_d.done = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign done = s_q.done;

endmodule : ssa_conv_core

`default_nettype wire

// *** design/ssa_device.sv ***
/*
 * Sequencer end of the converter: sampling, channel sequencing, result store and bus slave.
 * Assumes the analog front end presents an offset-binary code per channel on sampleCode.
 * Assumes the host drives one strobe cycle at a time on the link.
 */
`include "ssa_regs.svh"
`default_nettype none

module ssa_device
   import ssa_pkg::*;
(
   input  wire logic                                       clk_sys,
   input  wire logic                                       arst_n,
   input  wire logic                                       ce,
   input  wire logic [`SSA_CHANNELS-1:0][`SSA_DATA_W-1:0]  sampleCode,
   input  wire logic                                       codingBipolar,
   input  wire logic [`SSA_MASK_W-1:0]                     channelMaskPins,
   input  wire logic                                       hwSwSelect,
   input  wire logic                                       clockSourceSelect,
   input  wire logic                                       externalConversionClock,
   output logic                                            trackHold,
   ssa_if.dev                                              link
);

   ssa_dev_state_t s_q;
   ssa_dev_state_t s_d;
   logic           coreDone;
   logic           rdAct;
   logic           wrAct;
   logic [2:0]     nextChan;
   ssa_mask_t      liveMask;
   logic [2:0]     firstChan;
   logic           startEdge;
   logic           readDone;
   ssa_word_t      coded [`SSA_CHANNELS];

   // ---------------------------------------------------------------
   // Channel search
   // ---------------------------------------------------------------
   // Returns the lowest selected channel at or above the start index; bit 2 set means none.
   function automatic logic [2:0] ssa_pick(input ssa_mask_t m, input logic [2:0] from);
      logic [2:0] r;

      r = 3'h4;
      for (int i = `SSA_CHANNELS - 1; i >= 0; i--) begin
         if (m[i] && (3'(i) >= from)) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction : ssa_pick

   // Two's complement for bipolar ranges, straight binary otherwise.
   function automatic ssa_word_t ssa_code(input ssa_word_t raw, input logic bip);
      ssa_word_t r;

      r = bip ? {~raw[`SSA_DATA_W-1], raw[`SSA_DATA_W-2:0]} : raw;
      return r;
   endfunction : ssa_code

   // ---------------------------------------------------------------
   // Conversion timer
   // ---------------------------------------------------------------
   ssa_conv_core i_ssa_conv_core (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .ce      (ce),
      .start   (s_q.coreStart),
      .extSel  (clockSourceSelect),
      .extClk  (externalConversionClock),
      .done    (coreDone)
   );

   // ---------------------------------------------------------------
   // Output coding per channel
   // ---------------------------------------------------------------
   for (genvar g = 0; g < `SSA_CHANNELS; g++) begin : g_chan
      assign coded[g] = ssa_code(s_q.held[g], codingBipolar);
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.coreStart = 1'b0;
      s_d.startPrev = link.sampleStart_n;
      rdAct = !link.chipSel_n && !link.readStb_n;
      wrAct = !link.chipSel_n && !link.writeStb_n && link.readStb_n;
      liveMask = hwSwSelect ? s_q.chanSel : channelMaskPins;
      nextChan = ssa_pick(s_q.seqMask, {1'b0, s_q.chan} + 3'h1);
      firstChan = ssa_pick(liveMask, 3'h0);
      startEdge = !s_q.startPrev && link.sampleStart_n;
      readDone = s_q.rdPrev && !rdAct;

      // ---------------------------------------------------------------
      // Mask register: line 0 is channel 1 up to line 3 as channel 4.
      // ---------------------------------------------------------------
      if (wrAct) begin
         s_d.chanSel = link.dataBus[`SSA_MASK_LSB +: `SSA_MASK_W];
      end

      // ---------------------------------------------------------------
      // Each completed read steps to the next stored result in channel order.
      // ---------------------------------------------------------------
      s_d.rdPrev = rdAct;
      if (readDone && (s_q.rdPos < s_q.wrPos)) begin
         s_d.rdPos = s_q.rdPos + 3'h1;
      end
      s_d.dout = s_q.res[s_q.rdPos[1:0]];
      s_d.doutOe_n = !rdAct;

      // ---------------------------------------------------------------
      // Sequence control
      // ---------------------------------------------------------------
      case (s_q.st)
         DEV_IDLE: begin
            if (startEdge) begin
               s_d.held = sampleCode;
               s_d.seqMask = liveMask;
               s_d.busy = 1'b1;
               s_d.hold = 1'b1;
               s_d.wrPos = 3'h0;
               s_d.rdPos = 3'h0;
               if (!firstChan[2]) begin
                  s_d.chan = firstChan[1:0];
                  s_d.coreStart = 1'b1;
                  s_d.st = DEV_CONV;
               end else begin
                  s_d.st = DEV_FIN;
               end
            end
         end

         DEV_CONV: begin
            if (coreDone) begin
               s_d.res[s_q.wrPos[1:0]] = coded[s_q.chan];
               s_d.wrPos = s_q.wrPos + 3'h1;
               s_d.eoc_n = 1'b0;
               s_d.eocCnt = 3'(`SSA_EOC_CYC - 1);
               s_d.st = DEV_EOC;
            end
         end

         DEV_EOC: begin
            if (s_q.eocCnt == 3'h0) begin
               s_d.eoc_n = 1'b1;
               if (!nextChan[2]) begin
                  s_d.chan = nextChan[1:0];
                  s_d.coreStart = 1'b1;
                  s_d.st = DEV_CONV;
               end else begin
                  s_d.st = DEV_FIN;
               end
            end else begin
               s_d.eocCnt = s_q.eocCnt - 3'h1;
            end
         end

         DEV_FIN: begin
            s_d.busy = 1'b0;
            s_d.hold = 1'b0;
            s_d.st = DEV_IDLE;
         end

         default: begin
            s_d.st = DEV_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_q.st <= DEV_IDLE;
         s_q.startPrev <= 1'b1;
         s_q.chanSel <= `SSA_MASK_RST;
         s_q.seqMask <= '0;
         s_q.chan <= 2'h0;
         s_q.held <= '0;
         s_q.res <= '0;
         s_q.wrPos <= 3'h0;
         s_q.rdPos <= 3'h0;
         s_q.rdPrev <= 1'b0;
         s_q.eocCnt <= 3'h0;
         s_q.busy <= 1'b0;
         s_q.eoc_n <= 1'b1;
         s_q.hold <= 1'b0;
         s_q.dout <= '0;
         s_q.doutOe_n <= 1'b1;
         s_q.coreStart <= 1'b0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign trackHold = s_q.hold;
   assign link.busy = s_q.busy;
   assign link.eoc_n = s_q.eoc_n;
   assign link.devData = s_q.dout;
   assign link.devOe_n = s_q.doutOe_n;

endmodule : ssa_device

`default_nettype wire

// *** design/ssa_host.sv ***
/*
 * Host end: writes the mask register, pulses the start, and reads results.
 * Assumes the sequencer end shares clk_sys.
 */
`include "ssa_regs.svh"
`default_nettype none

module ssa_host
   import ssa_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   arst_n,
   input  wire logic                   ce,
   input  wire logic                   startReq,
   input  wire logic                   readAfter,
   input  wire logic                   maskWrReq,
   input  wire logic [`SSA_MASK_W-1:0] maskWrData,
   output logic                        ready,
   output logic                        resultValid,
   output logic [`SSA_DATA_W-1:0]      resultData,
   output logic [2:0]                  resultIdx,
   ssa_if.host                         link
);

   ssa_hst_state_t s_q;
   ssa_hst_state_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.resValid = 1'b0;
      s_d.busyPrev = link.busy;
      s_d.eocPrev = link.eoc_n;
      if (s_q.quiet != '1) begin
         s_d.quiet = s_q.quiet + 1'b1;
      end
      if (s_q.busyPrev && !link.busy) begin
         s_d.seqEnd = 1'b1;
         s_d.quiet = '0;
      end
      if (s_q.eocPrev && !link.eoc_n) begin
         s_d.nEoc = s_q.nEoc + 3'h1;
      end
      s_d.ready = (s_q.st == HST_IDLE);

      case (s_q.st)
         HST_IDLE: begin
            if (maskWrReq) begin
               s_d.chipSel_n = 1'b0;
               s_d.writeStb_n = 1'b0;
               s_d.hData = maskWrData;
               s_d.hOe_n = 1'b0;
               s_d.cnt = '0;
               s_d.ready = 1'b0;
               s_d.st = HST_WRITE;
            end else if (startReq && (s_q.quiet >= ssa_cnt_t'(`SSA_ACQ_CYC))
                         && (s_q.quiet >= ssa_cnt_t'(`SSA_GAP_CYC))) begin
               s_d.start_n = 1'b0;
               s_d.cnt = '0;
               s_d.seqEnd = 1'b0;
               s_d.nEoc = 3'h0;
               s_d.rdCnt = 3'h0;
               s_d.ready = 1'b0;
               s_d.st = HST_START;
            end
         end
         HST_WRITE: begin
            s_d.cnt = s_q.cnt + 1'b1;
            if (s_q.cnt == ssa_cnt_t'(`SSA_STB_CYC - 1)) begin
               s_d.chipSel_n = 1'b1;
               s_d.writeStb_n = 1'b1;
               s_d.hOe_n = 1'b1;
               s_d.st = HST_IDLE;
            end
         end
         HST_START: begin
            s_d.cnt = s_q.cnt + 1'b1;
            if (s_q.cnt == ssa_cnt_t'(`SSA_START_CYC - 1)) begin
               s_d.start_n = 1'b1;
               s_d.st = HST_WAIT;
            end
         end
         HST_WAIT: begin
            if ((s_q.rdCnt < s_q.nEoc) && (!readAfter || s_q.seqEnd)) begin
               s_d.chipSel_n = 1'b0;
               s_d.readStb_n = 1'b0;
               s_d.cnt = '0;
               s_d.st = HST_READ;
            end else if (s_q.seqEnd) begin
               s_d.st = HST_IDLE;
            end
         end
         HST_READ: begin
            s_d.cnt = s_q.cnt + 1'b1;
            if (s_q.cnt == ssa_cnt_t'(`SSA_STB_CYC - 1)) begin
               s_d.chipSel_n = 1'b1;
               s_d.readStb_n = 1'b1;
               s_d.resValid = 1'b1;
               s_d.resData = link.dataBus;
               s_d.resIdx = s_q.rdCnt;
               s_d.rdCnt = s_q.rdCnt + 3'h1;
               s_d.quiet = '0;
               s_d.st = HST_WAIT;
            end
         end
         default: begin
            s_d.st = HST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
         s_q.st <= HST_IDLE;
         s_q.quiet <= '1;
         s_q.eocPrev <= 1'b1;
         s_q.start_n <= 1'b1;
         s_q.chipSel_n <= 1'b1;
         s_q.readStb_n <= 1'b1;
         s_q.writeStb_n <= 1'b1;
         s_q.hOe_n <= 1'b1;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign ready = s_q.ready;
   assign resultValid = s_q.resValid;
   assign resultData = s_q.resData;
   assign resultIdx = s_q.resIdx;
   assign link.sampleStart_n = s_q.start_n;
   assign link.chipSel_n = s_q.chipSel_n;
   assign link.readStb_n = s_q.readStb_n;
   assign link.writeStb_n = s_q.writeStb_n;
   assign link.hostData = s_q.hData;
   assign link.hostOe_n = s_q.hOe_n;

endmodule : ssa_host

`default_nettype wire

// *** testbench/ssa_link_checker.sv ***
/*
 * Checker of the link between the host and the sequencer ends.
 * Assumes one clock domain; instantiated beside the link interface.
 */
`include "ssa_regs.svh"
`default_nettype none

module ssa_link_checker
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic sampleStart_n,
   input wire logic chipSel_n,
   input wire logic readStb_n,
   input wire logic writeStb_n,
   input wire logic hostOe_n,
   input wire logic devOe_n,
   input wire logic busy,
   input wire logic eoc_n
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [8:0] sinceRd_q;
   logic [8:0] sinceBusy_q;

   // ---------------------------------------------------------------
   // Cycles since the last read and since busy was last high
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sinceRd_q   <= 9'h1ff;
         sinceBusy_q <= 9'h1ff;
      end else begin
         sinceRd_q   <= !readStb_n ? 9'h000 : sinceRd_q + {8'h00, ~&sinceRd_q};
         sinceBusy_q <= busy ? 9'h000 : sinceBusy_q + {8'h00, ~&sinceBusy_q};
      end
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   sequence s_eocLow;
      !eoc_n [*4] ##1 eoc_n;
   endsequence
   sequence s_startLow;
      !sampleStart_n [*4] ##1 sampleStart_n;
   endsequence

   a_start_busy: assert property ($rose(sampleStart_n) && !busy |-> ##[1:2] busy)
      else $error("busy did not follow start");
   a_start_pulse: assert property ($fell(sampleStart_n) |-> s_startLow)
      else $error("start pulse width wrong");
   a_eoc_pulse: assert property ($fell(eoc_n) |-> s_eocLow)
      else $error("end of conversion pulse width wrong");
   a_eoc_in_busy: assert property (!eoc_n |=> busy)
      else $error("end of conversion outside busy");
   a_rd_drive: assert property (!chipSel_n && !readStb_n |=> !devOe_n)
      else $error("data not driven during read");
   a_rd_release: assert property (chipSel_n || readStb_n |=> devOe_n)
      else $error("data driven outside read");
   a_no_clash: assert property (devOe_n || hostOe_n)
      else $error("both ends drive the data lines");
   a_wr_cycle: assert property ($fell(writeStb_n) |-> (!writeStb_n && !chipSel_n && !hostOe_n && readStb_n) [*3]
                                ##1 writeStb_n)
      else $error("mask write cycle malformed");
   a_rd_cycle: assert property ($fell(readStb_n) |-> (!readStb_n && !chipSel_n) [*3] ##1 readStb_n)
      else $error("read cycle malformed");
   a_read_gap: assert property ($rose(sampleStart_n) |-> sinceRd_q >= `SSA_GAP_CYC)
      else $error("read too close to start");
   a_acq_wait: assert property ($rose(sampleStart_n) |-> sinceBusy_q >= `SSA_ACQ_CYC)
      else $error("start before acquisition time");
endmodule : ssa_link_checker

`default_nettype wire

// *** testbench/test_simul_sample_adc_sequencer.sv ***
/*
 * Self-checking bench joining the host and sequencer ends over the link.
 * Assumes the design files and the link checker are compiled first.
 */
`include "ssa_regs.svh"
`default_nettype none

module test_simul_sample_adc_sequencer
   import ssa_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      ssa_word_t  data;
      logic [2:0] idx;
   } ssa_exp_t;

   logic                                      clk_sys;
   logic                                      arst_n;
   logic [`SSA_CHANNELS-1:0][`SSA_DATA_W-1:0] sampleCode;
   logic                                      codingBipolar, hwSwSelect, clockSourceSelect, extClk;
   logic                                      startReq, readAfter, maskWrReq, ready, resultValid, trackHold;
   ssa_mask_t                                 maskWrData, maskPins, regMask;
   ssa_word_t                                 resultData;
   logic [2:0]                                resultIdx;
   logic                                      prevEoc, prevBusy;
   ssa_exp_t                                  expQ[$];
   ssa_exp_t                                  e;
   integer                                    seed;
   int                                        failCount, samplesChecked, cyc, mark, lo, i, r;

   ssa_if link ();
   ssa_device i_ssa_device (.clk_sys(clk_sys), .arst_n(arst_n), .ce(1'b1), .sampleCode(sampleCode),
      .codingBipolar(codingBipolar), .channelMaskPins(maskPins), .hwSwSelect(hwSwSelect),
      .clockSourceSelect(clockSourceSelect), .externalConversionClock(extClk), .trackHold(trackHold),
      .link(link.dev));
   ssa_host i_ssa_host (.clk_sys(clk_sys), .arst_n(arst_n), .ce(1'b1), .startReq(startReq),
      .readAfter(readAfter), .maskWrReq(maskWrReq), .maskWrData(maskWrData), .ready(ready),
      .resultValid(resultValid), .resultData(resultData), .resultIdx(resultIdx), .link(link.host));
   ssa_link_checker i_ssa_link_checker (.clk_sys(clk_sys), .arst_n(arst_n), .sampleStart_n(link.sampleStart_n),
      .chipSel_n(link.chipSel_n), .readStb_n(link.readStb_n), .writeStb_n(link.writeStb_n),
      .hostOe_n(link.hostOe_n), .devOe_n(link.devOe_n), .busy(link.busy), .eoc_n(link.eoc_n));

   always #2 clk_sys = ~clk_sys;

   always begin
      repeat (2) @(posedge clk_sys);
      #1 extClk = ~extClk;
   end

   // ---------------------------------------------------------------
   // Compare tasks
   // ---------------------------------------------------------------
   task automatic checkWord(input ssa_word_t got, input ssa_word_t exp, input string what);
      samplesChecked++;
      if (got !== exp) begin
         failCount++;
         $display("[FAIL] %0t %s: got %h, expected %h", $time, what, got, exp);
      end
   endtask : checkWord

   task automatic checkLevel(input logic got, input logic exp, input string what);
      samplesChecked++;
      if (got !== exp) begin
         failCount++;
         $display("[FAIL] %0t %s: got %b, expected %b", $time, what, got, exp);
      end
   endtask : checkLevel

   task automatic checkRange(input int v, input int lo, input int hi, input string what);
      samplesChecked++;
      if (v < lo || v > hi) begin
         failCount++;
         $display("[FAIL] %0t %s: %0d outside %0d..%0d", $time, what, v, lo, hi);
      end
   endtask : checkRange

   task automatic finishTest();
      $display("comparisons %0d, mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finishTest

   // ---------------------------------------------------------------
   // Drivers
   // ---------------------------------------------------------------
   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic waitReady(input logic lvl);
      int n;
      n = 0;
      while (ready !== lvl && n < 20000) begin
         tick();
         n++;
      end
      checkRange(n, 0, 19999, "ready wait");
   endtask : waitReady

   task automatic runSeq(input logic sw, input logic after, input logic bip, input logic ext,
                         input logic doWr, input ssa_mask_t wr);
      ssa_mask_t m;
      int        k;
      int        n;
      waitReady(1'b1);
      hwSwSelect = sw;
      readAfter = after;
      codingBipolar = bip;
      clockSourceSelect = ext;
      maskPins = ssa_mask_t'($random(seed));
      for (k = 0; k < `SSA_CHANNELS; k++) sampleCode[k] = ssa_word_t'($random(seed));
      if (doWr) begin
         maskWrData = wr;
         maskWrReq = 1'b1;
         tick();
         maskWrReq = 1'b0;
         repeat (2) tick();
         waitReady(1'b1);
         regMask = wr;
      end
      m = sw ? regMask : maskPins;
      n = 0;
      for (k = 0; k < `SSA_CHANNELS; k++) begin
         if (m[k]) begin
            expQ.push_back('{data: bip ? sampleCode[k] ^ 12'h800 : sampleCode[k], idx: 3'(n)});
            n++;
         end
      end
      startReq = 1'b1;
      waitReady(1'b0);
      startReq = 1'b0;
      repeat (8) tick();
      maskPins = ~maskPins;
      sampleCode = ~sampleCode;
      waitReady(1'b1);
      repeat (4) tick();
      checkRange(expQ.size(), 0, 0, "results not read");
      expQ.delete();
   endtask : runSeq

   // ---------------------------------------------------------------
   // Result monitor
   // ---------------------------------------------------------------
   always @(posedge clk_sys) begin
      cyc++;
      if (arst_n === 1'b1) begin
         checkLevel(trackHold, link.busy, "track hold");
         if (link.busy === 1'b1 && prevBusy !== 1'b1) mark = cyc;
         if (link.eoc_n === 1'b0 && prevEoc === 1'b1) begin
            lo = clockSourceSelect ? 52 : `SSA_CONV_CYC;
            checkRange(cyc - mark, lo, lo + 16, "conversion time");
            mark = cyc;
         end
         if (resultValid === 1'b1) begin
            if (expQ.size() == 0) begin
               failCount++;
               $display("[FAIL] %0t result with none expected", $time);
            end else begin
               e = expQ.pop_front();
               checkWord(resultData, e.data, "result word");
               checkWord({9'h000, resultIdx}, {9'h000, e.idx}, "read index");
            end
         end
      end
      prevEoc = link.eoc_n;
      prevBusy = link.busy;
   end

   initial begin
      repeat (50000) @(posedge clk_sys);
      failCount++;
      $display("[FAIL] %0t watchdog expired", $time);
      finishTest();
   end

   initial begin
      clk_sys = 1'b0;
      arst_n = 1'b0;
      extClk = 1'b0;
      seed = 32'hf4bf98e0;
      sampleCode = '0;
      {codingBipolar, hwSwSelect, clockSourceSelect, startReq, readAfter, maskWrReq} = 6'h00;
      maskWrData = 4'h0;
      maskPins = 4'h0;
      regMask = `SSA_MASK_RST;
      repeat (16) @(posedge clk_sys);
      #1 arst_n = 1'b1;
      repeat (2) tick();
      runSeq(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
      runSeq(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'h5);
      runSeq(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'h0);
      runSeq(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'h8);
      runSeq(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
      for (i = 0; i < 6; i++) begin
         r = $random(seed);
         runSeq(r[0], r[1], r[2], r[3], r[4], r[8:5]);
      end
      finishTest();
   end
endmodule : test_simul_sample_adc_sequencer

`default_nettype wire
